// file: inc/profile_sync_defines.svh
// Register offsets, field positions, reset values and timing figures of the
// profile and sync register bank. Definitions only; included by bare name.
`ifndef PROFILE_SYNC_DEFINES_SVH
`define PROFILE_SYNC_DEFINES_SVH
`define ADDR_SYNC 5'h0A
`define ADDR_PROFILE_FIRST 5'h0E
`define ADDR_PROFILE_LAST 5'h15
`define ADDR_RAM_WORD 5'h16
`define ADDR_PIN_DIR 5'h18
`define ADDR_PIN_DATA 5'h19
`define SYNC_VALID_DELAY_HI 31
`define SYNC_VALID_DELAY_LO 28
`define SYNC_RX_EN_BIT 27
`define SYNC_GEN_EN_BIT 26
`define SYNC_GEN_POL_BIT 25
`define SYNC_PRESET_HI 23
`define SYNC_PRESET_LO 18
`define SYNC_GEN_DELAY_HI 15
`define SYNC_GEN_DELAY_LO 11
`define SYNC_RX_DELAY_HI 7
`define SYNC_RX_DELAY_LO 3
`define SYNC_WRITE_MASK 32'hFEFC_F8F8
`define SYNC_RESET 32'h0000_0000
`define PROFILE_RESET 64'h0000_0000_0000_0000
`define TONE_UNUSED_MASK 64'h3FFF_FFFF_FFFF_FFFF
`define PIN_DIR_RESET 16'h0000
`define PIN_DATA_RESET 16'h0000
`define SEG_START_HI 15
`define SEG_START_LO 6
`define SEG_END_HI 31
`define SEG_END_LO 22
`define DELAY_STEP_PS 150
`endif

// file: inc/profile_sync_pkg.sv
// Types shared by the profile and sync register bank and its bench.
// Assumes the operating mode codes of the first control word below.
package profile_sync_pkg;
   typedef enum logic [1:0] {
      MODE_UPCONV = 2'b00,
      MODE_TONE = 2'b01,
      MODE_INTERP = 2'b10,
      MODE_INTERP_ALT = 2'b11
   } op_mode_t;
   typedef enum logic [0:0] {
      RAM_IDLE = 1'b0,
      RAM_FILL = 1'b1
   } ram_state_t;
   typedef struct packed {
      logic [3:0] valid_delay;
      logic rx_en;
      logic gen_en;
      logic gen_pol;
      logic [5:0] preset;
      logic [4:0] gen_delay;
      logic [4:0] rx_delay;
   } sync_cfg_t;
   typedef struct packed {
      logic [1:0] unused;
      logic [13:0] amplitude;
      logic [15:0] phase;
      logic [31:0] freq;
   } tone_profile_t;
   typedef struct packed {
      logic [5:0] interp_rate;
      logic spec_inv;
      logic inv_cic_bypass;
      logic [7:0] out_scale;
      logic [15:0] phase;
      logic [31:0] freq;
   } upconv_profile_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [4:0] addr;
      logic [63:0] data;
   } reg_req_t;
endpackage : profile_sync_pkg

// file: rtl/profile_and_sync_register_bank.sv
// Upper control register bank: multichip sync settings, eight profiles,
// waveform memory write port and general purpose pin registers.
// Assumes the serial port front end delivers decoded whole-register accesses
// synchronous to ref_clk, and that segment bounds come from the segment logic.
//
// Contract
// - sync bits 31:28 hold a 4-bit validation delay, steps near 150 ps.
// - sync bit 27 enables the sync receiver; cleared by reset.
// - sync bit 26 enables the sync generator; cleared by reset.
// - sync bit 25 picks generator edge: 0 rising, 1 falling; default 0.
// - sync bits 23:18 preset; generator state loads it on each sync pulse while bit 27 is set.
// - sync bits 15:11 hold generator output delay, default zero.
// - sync bits 7:3 hold receiver input delay, default zero.
// - sync register at 0x0A, four bytes; bits 24,17:16,10:8,2:0 unused.
// - profiles at 0x0E..0x15; mode bits 25:24 pick tone or upconverter view.
// - active profile is the one chosen by the three profile pins.
// - tone view: amplitude 61:48, phase 47:32, frequency 31:0, 63:62 unused.
// - upconverter view: interpolation rate 63:58, phase and frequency kept.
// - upconverter bit 57 selects spectral inversion sign of the sine term.
// - upconverter bit 56 set bypasses the inverse compensation filter.
// - upconverter bits 55:48 hold the 8-bit output scale factor.
// - interpolating mode uses only scale, rate and bypass; others ignored.
// - words written at 0x16 go to memory, count bounded by segment range.
// - pin data at 0x19 read or written per pin by direction at 0x18.
// - segment start in bits 15:6, end in bits 31:22, bound writes.
`timescale 1ns/1ns
`include "profile_sync_defines.svh"
module profile_and_sync_register_bank
   import profile_sync_pkg::*;
#(
   parameter int PROFILE_COUNT = 8,
   parameter int PIN_COUNT = 16,
   parameter int RAM_ADDR_W = 10
) (
   // Clock, reset and enable
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   // Decoded register access from the serial port
   input wire reg_req_t reg_req,
   output logic [63:0] rd_data,
   output logic rd_valid,
   // Operating mode and profile pins
   input wire logic [1:0] op_mode,
   input wire logic [2:0] profile_pins,
   // Sync chain
   input wire logic sync_pulse_in,
   output sync_cfg_t sync_cfg,
   output logic [5:0] sync_gen_state,
   // Active parameter set
   output logic [2:0] active_index,
   output tone_profile_t active_tone,
   output upconv_profile_t active_upconv,
   // Waveform memory
   input wire logic ram_seq_start,
   input wire logic [31:0] ram_segment,
   output logic ram_wr_en,
   output logic [RAM_ADDR_W-1:0] ram_wr_addr,
   output logic [31:0] ram_wr_data,
   output logic ram_overrun,
   // General purpose pins
   input wire logic [PIN_COUNT-1:0] pin_in,
   output logic [PIN_COUNT-1:0] pin_out,
   output logic [PIN_COUNT-1:0] pin_oe
);

   // Refuse sizes that the fixed field layout cannot serve
   if (PROFILE_COUNT != 8) begin : g_bad_profiles
      $error("profile count must be 8");
   end
   if (PIN_COUNT < 1 || PIN_COUNT > 16) begin : g_bad_pins
      $error("pin count must be 1 to 16");
   end
   if (RAM_ADDR_W != 10) begin : g_bad_ram
      $error("memory address width must be 10");
   end

   // Limits a user must know: the delay fields are only handed out, the
   // delay lines themselves sit elsewhere; a fill whose end lies below its
   // start wraps the 10-bit pointer and runs through the top of memory.

   // Register state
   logic [31:0] sync_reg;
   logic [63:0] profile_reg [PROFILE_COUNT];
   logic [31:0] ram_word;
   logic [PIN_COUNT-1:0] pin_dir;
   logic [PIN_COUNT-1:0] pin_latch;
   logic [2:0] pins_meta;
   logic [2:0] pins_sync;
   ram_state_t ram_state;
   logic [RAM_ADDR_W-1:0] ram_ptr;
   logic [RAM_ADDR_W-1:0] ram_end;

   // Address decode
   wire sel_sync = reg_req.addr == `ADDR_SYNC;
   wire sel_profile = reg_req.addr >= `ADDR_PROFILE_FIRST && reg_req.addr <= `ADDR_PROFILE_LAST;
   wire sel_ram = reg_req.addr == `ADDR_RAM_WORD;
   wire sel_dir = reg_req.addr == `ADDR_PIN_DIR;
   wire sel_data = reg_req.addr == `ADDR_PIN_DATA;
   // Offset is meaningless outside the profile range; sel_profile guards every use
   wire [4:0] profile_off = reg_req.addr - `ADDR_PROFILE_FIRST;
   wire [2:0] profile_sel = profile_off[2:0];
   wire wr_go = ce && reg_req.wr;
   wire rd_go = ce && reg_req.rd;

   // Sync register write, unused bits masked out
   // Unused bits are cleared on the way in, so a read shows them as zero
   wire [31:0] next_sync = reg_req.data[31:0] & `SYNC_WRITE_MASK;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sync_reg <= `SYNC_RESET;
      end else if (wr_go && sel_sync) begin
         sync_reg <= next_sync;
      end
   end

   // Sync field outputs
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sync_cfg <= '0;
      end else if (ce) begin
         sync_cfg.valid_delay <= sync_reg[`SYNC_VALID_DELAY_HI:`SYNC_VALID_DELAY_LO];
         sync_cfg.rx_en <= sync_reg[`SYNC_RX_EN_BIT];
         sync_cfg.gen_en <= sync_reg[`SYNC_GEN_EN_BIT];
         sync_cfg.gen_pol <= sync_reg[`SYNC_GEN_POL_BIT];
         sync_cfg.preset <= sync_reg[`SYNC_PRESET_HI:`SYNC_PRESET_LO];
         sync_cfg.gen_delay <= sync_reg[`SYNC_GEN_DELAY_HI:`SYNC_GEN_DELAY_LO];
         sync_cfg.rx_delay <= sync_reg[`SYNC_RX_DELAY_HI:`SYNC_RX_DELAY_LO];
      end
   end

   // Internal clock generator state; a received pulse forces the preset
   // Free-running between pulses; the counter wraps at 64
   wire sync_load = sync_reg[`SYNC_RX_EN_BIT] && sync_pulse_in;
   wire [5:0] next_gen_state = sync_load ? sync_reg[`SYNC_PRESET_HI:`SYNC_PRESET_LO]
                                         : sync_gen_state + 6'h01;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sync_gen_state <= 6'h00;
      end else if (ce) begin
         sync_gen_state <= next_gen_state;
      end
   end

   // Profile storage, one 64-bit register per profile
   genvar gi;
   generate
      for (gi = 0; gi < PROFILE_COUNT; gi++) begin : g_profile
         wire hit = wr_go && sel_profile && profile_sel == 3'(gi);
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               profile_reg[gi] <= `PROFILE_RESET;
            end else if (hit) begin
               profile_reg[gi] <= reg_req.data;
            end
         end
      end
   endgenerate

   // Profile pins pass two flops before they may switch the set
   // A pin change shows three edges later, and a set is switched whole
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pins_meta <= 3'h0;
         pins_sync <= 3'h0;
      end else if (ce) begin
         pins_meta <= profile_pins;
         pins_sync <= pins_meta;
      end
   end

   // Views of the selected profile under the present mode
   op_mode_t mode;
   assign mode = op_mode_t'(op_mode);
   wire [63:0] chosen = profile_reg[pins_sync];
   wire tone_mode = mode == MODE_TONE;
   wire interp_mode = mode == MODE_INTERP || mode == MODE_INTERP_ALT;
   wire upconv_mode = !tone_mode;
   tone_profile_t next_tone;
   upconv_profile_t next_upconv;
   assign next_tone = tone_mode ? tone_profile_t'(chosen & `TONE_UNUSED_MASK) : '0;
   always_comb begin
      next_upconv = upconv_mode ? upconv_profile_t'(chosen) : '0;
      if (interp_mode) begin
         next_upconv.freq = 32'h0000_0000;
         next_upconv.phase = 16'h0000;
         next_upconv.spec_inv = 1'b0;
      end
   end

   // Active set registers
   // Both views are registered, so a mode change never glitches an output
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         active_index <= 3'h0;
         active_tone <= '0;
         active_upconv <= '0;
      end else if (ce) begin
         active_index <= pins_sync;
         active_tone <= next_tone;
         active_upconv <= next_upconv;
      end
   end

   // Waveform memory fill sequencer
   wire [RAM_ADDR_W-1:0] seg_start = ram_segment[`SEG_START_HI:`SEG_START_LO];
   wire [RAM_ADDR_W-1:0] seg_end = ram_segment[`SEG_END_HI:`SEG_END_LO];
   wire ram_write = wr_go && sel_ram;
   wire ram_accept = ram_write && ram_state == RAM_FILL;
   wire ram_last = ram_ptr == ram_end;
   ram_state_t next_ram_state;
   always_comb begin
      next_ram_state = ram_state;
      unique case (ram_state)
         RAM_IDLE: begin
            if (ram_seq_start) begin
               next_ram_state = RAM_FILL;
            end
         end
         RAM_FILL: begin
            if (ram_seq_start) begin
               next_ram_state = RAM_FILL;
            end else if (ram_accept && ram_last) begin
               next_ram_state = RAM_IDLE;
            end
         end
      endcase
   end

   // Pointer and segment end latch
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ram_state <= RAM_IDLE;
         ram_ptr <= '0;
         ram_end <= '0;
      end else if (ce) begin
         ram_state <= next_ram_state;
         if (ram_seq_start) begin
            ram_ptr <= seg_start;
            ram_end <= seg_end;
         end else if (ram_accept && !ram_last) begin
            ram_ptr <= ram_ptr + RAM_ADDR_W'(1);
         end
      end
   end

   // Memory write strobe with address and data of each accepted word
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ram_wr_en <= 1'b0;
         ram_wr_addr <= '0;
         ram_wr_data <= 32'h0000_0000;
      end else if (ce) begin
         ram_wr_en <= ram_accept;
         if (ram_accept) begin
            ram_wr_addr <= ram_ptr;
            ram_wr_data <= reg_req.data[31:0];
         end
      end
   end

   // Last word written at 0x16, accepted or dropped, kept for read back
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ram_word <= 32'h0000_0000;
      end else if (ram_write) begin
         ram_word <= reg_req.data[31:0];
      end
   end

   // Sticky flag for words beyond the segment; a word dropped in the same
   // cycle as a restart still sets it, so no overrun is ever lost
   wire ram_drop = ram_write && ram_state == RAM_IDLE;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ram_overrun <= 1'b0;
      end else if (ce) begin
         if (ram_drop) begin
            ram_overrun <= 1'b1;
         end else if (ram_seq_start) begin
            ram_overrun <= 1'b0;
         end
      end
   end

   // Pin direction and output latch
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pin_dir <= PIN_COUNT'(`PIN_DIR_RESET);
         pin_latch <= PIN_COUNT'(`PIN_DATA_RESET);
      end else begin
         if (wr_go && sel_dir) begin
            pin_dir <= reg_req.data[PIN_COUNT-1:0];
         end
         if (wr_go && sel_data) begin
            pin_latch <= reg_req.data[PIN_COUNT-1:0];
         end
      end
   end

   // Pins drive the latch where configured as outputs
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pin_out <= '0;
         pin_oe <= '0;
      end else if (ce) begin
         pin_out <= pin_latch & pin_dir;
         pin_oe <= pin_dir;
      end
   end

   // Read data: output pins show the latch, input pins show the pin level
   // A write and read in one cycle return the old value, taken before the edge
   wire [PIN_COUNT-1:0] pin_view = (pin_latch & pin_dir) | (pin_in & ~pin_dir);
   logic [63:0] next_rd;
   always_comb begin
      next_rd = 64'h0000_0000_0000_0000;
      if (sel_sync) begin
         next_rd = {32'h0000_0000, sync_reg};
      end else if (sel_profile) begin
         next_rd = profile_reg[profile_sel];
      end else if (sel_ram) begin
         next_rd = {32'h0000_0000, ram_word};
      end else if (sel_dir) begin
         next_rd[PIN_COUNT-1:0] = pin_dir;
      end else if (sel_data) begin
         next_rd[PIN_COUNT-1:0] = pin_view;
      end
   end

   // Registered read answer, one cycle after the request
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rd_data <= 64'h0000_0000_0000_0000;
         rd_valid <= 1'b0;
      end else if (ce) begin
         rd_valid <= rd_go;
         if (rd_go) begin
            rd_data <= next_rd;
         end
      end
   end

endmodule : profile_and_sync_register_bank

// file: verification/sync_bank_props.sv
// Checker for the profile and sync register bank.
// Sees only top-level ports; bound to every instance of the bank below.
`timescale 1ns/1ns
`include "profile_sync_defines.svh"
module sync_bank_props
   import profile_sync_pkg::*;
#(
   parameter int PIN_COUNT = 16
) (
   // Clock, reset and requests
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   input wire reg_req_t reg_req,
   input wire logic [1:0] op_mode,
   input wire logic [2:0] profile_pins,
   input wire logic sync_pulse_in,
   // Observed outputs
   input wire logic [63:0] rd_data,
   input wire logic rd_valid,
   input wire sync_cfg_t sync_cfg,
   input wire logic [5:0] sync_gen_state,
   input wire logic [2:0] active_index,
   input wire tone_profile_t active_tone,
   input wire upconv_profile_t active_upconv,
   input wire logic ram_wr_en,
   input wire logic [31:0] ram_wr_data,
   input wire logic [PIN_COUNT-1:0] pin_out,
   input wire logic [PIN_COUNT-1:0] pin_oe
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Read answers, masking, reset state and the sync preset
   AST_RD_ANSWER: assert property (!$past(rst) && $past(ce) |-> rd_valid == $past(reg_req.rd))
      else $error("read answer timing wrong");
   AST_SYNC_MASK: assert property (rd_valid && $past(reg_req.addr) == `ADDR_SYNC
      |-> (rd_data & ~{32'h0000_0000, `SYNC_WRITE_MASK}) == 64'h0) else $error("sync unused bits set");
   AST_RESET_CLEAR: assert property ($fell(rst) |-> sync_cfg == '0 && sync_gen_state == 6'h0)
      else $error("sync state not cleared by reset");
   AST_PRESET_LOAD: assert property ($past(sync_pulse_in && ce && !rst) && sync_cfg.rx_en
      |-> sync_gen_state == sync_cfg.preset) else $error("preset not loaded on sync pulse");
   // Profile views and selection
   AST_TONE_UNUSED: assert property (active_tone.unused == 2'h0) else $error("tone unused bits set");
   AST_INTERP_IGNORE: assert property (op_mode[1] && $past(op_mode[1]) && $past(op_mode[1], 2)
      |-> active_upconv.freq == 32'h0 && active_upconv.phase == 16'h0 && !active_upconv.spec_inv)
      else $error("interpolating view leaks ignored fields");
   AST_PROFILE_PATH: assert property (!($past(rst) || $past(rst, 2) || $past(rst, 3))
      && $past(ce) && $past(ce, 2) && $past(ce, 3) |-> active_index == $past(profile_pins, 3))
      else $error("active profile index lags wrongly");
   // Memory writes and pin drive
   AST_RAM_WRITE: assert property (ram_wr_en |-> $past(reg_req.wr && ce && reg_req.addr == `ADDR_RAM_WORD)
      && ram_wr_data == $past(reg_req.data[31:0])) else $error("memory write without cause");
   AST_PIN_DRIVE: assert property ((pin_out & ~pin_oe) == '0) else $error("pin data on input pin");
endmodule : sync_bank_props
bind profile_and_sync_register_bank sync_bank_props #(.PIN_COUNT(PIN_COUNT)) props_u (.*);

// file: verification/sync_chain_model.sv
// Neighbour in the sync chain: sends one sync pulse on request.
// Assumes the bench calls send at a falling clock edge.
`timescale 1ns/1ns
module sync_chain_model (
   // Clock
   input wire logic ref_clk,
   // Pulse towards the bank, low between pulses
   output logic sync_pulse_in
);
   initial sync_pulse_in = 1'h0;
   // One cycle pulse after lag idle cycles, prompt or slow
   task automatic send(input int lag);
      repeat (lag) @(negedge ref_clk);
      sync_pulse_in = 1'h1;
      @(negedge ref_clk);
      sync_pulse_in = 1'h0;
   endtask : send
endmodule : sync_chain_model

// file: verification/profile_and_sync_register_bank_tb_top.sv
// Self-checking bench for the profile and sync register bank.
// Assumes package, defines header, checker and sync model compile first.
`timescale 1ns/1ns
`include "profile_sync_defines.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module profile_and_sync_register_bank_tb_top;
   import profile_sync_pkg::*;
   logic ref_clk = 1'h0;
   logic rst = 1'h1;
   logic ce = 1'h1;
   reg_req_t reg_req = '0;
   logic [1:0] op_mode = 2'h0;
   logic [2:0] profile_pins = 3'h0;
   logic sync_pulse_in;
   logic ram_seq_start = 1'h0;
   logic [31:0] ram_segment = 32'h0;
   logic [15:0] pin_in = 16'h0;
   logic [63:0] rd_data;
   logic rd_valid;
   sync_cfg_t sync_cfg;
   logic [5:0] sync_gen_state;
   logic [2:0] active_index;
   tone_profile_t active_tone;
   upconv_profile_t active_upconv;
   logic ram_wr_en;
   logic ram_overrun;
   logic [9:0] ram_wr_addr;
   logic [31:0] ram_wr_data;
   logic [15:0] pin_out;
   logic [15:0] pin_oe;
   int n_fail = 0;
   int total_checks = 0;
   // Reference model of the register contents
   logic [63:0] m_prof [8];
   logic [31:0] m_sync = 32'h0;
   logic [15:0] m_dir = 16'h0;
   logic [15:0] m_dat = 16'h0;
   logic [63:0] v;
   int s;
   always #2 ref_clk = ~ref_clk;
   profile_and_sync_register_bank dut_u (.*);
   sync_chain_model sync_u (.ref_clk(ref_clk), .sync_pulse_in(sync_pulse_in));
   // One register access, driven and released at falling edges
   task automatic acc(input bit w, input logic [4:0] a, input logic [63:0] d);
      @(negedge ref_clk);
      reg_req = '{wr: w, rd: !w, addr: a, data: d};
      @(negedge ref_clk);
      reg_req = '0;
   endtask : acc
   // Write and mirror it into the model
   task automatic wr(input logic [4:0] a, input logic [63:0] d);
      acc(1'h1, a, d);
      if (ce) begin
         if (a == `ADDR_SYNC) m_sync = d[31:0] & `SYNC_WRITE_MASK;
         if (a >= `ADDR_PROFILE_FIRST && a <= `ADDR_PROFILE_LAST) m_prof[a - `ADDR_PROFILE_FIRST] = d;
         if (a == `ADDR_PIN_DIR) m_dir = d[15:0];
         if (a == `ADDR_PIN_DATA) m_dat = d[15:0];
      end
   endtask : wr
   function automatic logic [63:0] exp_rd(input logic [4:0] a);
      if (a == `ADDR_SYNC) return {32'h0, m_sync};
      if (a >= `ADDR_PROFILE_FIRST && a <= `ADDR_PROFILE_LAST) return m_prof[a - `ADDR_PROFILE_FIRST];
      if (a == `ADDR_PIN_DIR) return {48'h0, m_dir};
      if (a == `ADDR_PIN_DATA) return {48'h0, (m_dat & m_dir) | (pin_in & ~m_dir)};
      return 64'h0;
   endfunction : exp_rd
   task automatic rd_chk(input logic [4:0] a, input logic [63:0] e);
      acc(1'h0, a, 64'h0);
      `CHK("rd_valid", 1'h1, rd_valid)
      `CHK("rd_data", e, rd_data)
   endtask : rd_chk
   // Whole map read except 0x16, unmapped places included
   task automatic sweep();
      for (int a = 0; a < 32; a++) if (a != `ADDR_RAM_WORD) rd_chk(5'(a), exp_rd(5'(a)));
   endtask : sweep
   task automatic close_out();
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   initial begin
      #40000;
      n_fail++;
      close_out();
   end
   initial begin
      void'($urandom(53));
      foreach (m_prof[i]) m_prof[i] = 64'h0;
      repeat (16) @(posedge ref_clk);
      @(negedge ref_clk) rst = 1'h0;
      sweep();
      // Masked sync write, then a write lost while the clock enable is low
      wr(`ADDR_SYNC, {$urandom, $urandom});
      ce = 1'h0;
      wr(`ADDR_SYNC, 64'hFFFF_FFFF_FFFF_FFFF);
      ce = 1'h1;
      @(negedge ref_clk);
      `CHK("sync_cfg", {m_sync[31:25], m_sync[23:18], m_sync[15:11], m_sync[7:3]}, sync_cfg)
      rd_chk(`ADDR_SYNC, exp_rd(`ADDR_SYNC));
      // Receiver on, prompt and slow pulses from the neighbour
      wr(`ADDR_SYNC, {32'h0, $urandom | 32'h0800_0000});
      repeat (2) @(negedge ref_clk);
      for (int i = 0; i < 2; i++) begin
         sync_u.send(i * 5);
         `CHK("gen_state", m_sync[23:18], sync_gen_state)
         repeat (3) @(negedge ref_clk);
         `CHK("gen_count", 6'(m_sync[23:18] + 3), sync_gen_state)
      end
      // Random profiles, then every mode against every pin code
      for (int i = 0; i < 8; i++) wr(5'(`ADDR_PROFILE_FIRST + i), {$urandom, $urandom});
      sweep();
      for (int m = 0; m < 4; m++) for (int p = 0; p < 8; p++) begin
         op_mode = m[1:0];
         profile_pins = p[2:0];
         repeat (4) @(negedge ref_clk);
         v = m_prof[p];
         `CHK("index", p[2:0], active_index)
         `CHK("tone", (m == 1) ? {2'h0, v[61:0]} : 64'h0, active_tone)
         `CHK("upconv", (m == 1) ? 64'h0 : (m > 1) ? v & 64'hFDFF_0000_0000_0000 : v, active_upconv)
      end
      // Three-word memory segment, then one word too many
      s = $urandom_range(1020);
      ram_segment = {10'(s + 2), 6'h0, 10'(s), 6'h0};
      @(negedge ref_clk) ram_seq_start = 1'h1;
      @(negedge ref_clk) ram_seq_start = 1'h0;
      for (int i = 0; i < 4; i++) begin
         v = {$urandom, $urandom};
         wr(`ADDR_RAM_WORD, v);
         `CHK("ram_wr_en", i < 3, ram_wr_en)
         if (i < 3) `CHK("ram_word", {10'(s + i), v[31:0]}, {ram_wr_addr, ram_wr_data})
      end
      `CHK("overrun", 1'h1, ram_overrun)
      rd_chk(`ADDR_RAM_WORD, {32'h0, v[31:0]});
      @(negedge ref_clk) ram_seq_start = 1'h1;
      @(negedge ref_clk) ram_seq_start = 1'h0;
      `CHK("overrun_clear", 1'h0, ram_overrun)
      // Mixed pin directions and levels
      pin_in = 16'($urandom);
      wr(`ADDR_PIN_DIR, {48'h0, 16'($urandom)});
      wr(`ADDR_PIN_DATA, {$urandom, $urandom});
      repeat (2) @(negedge ref_clk);
      `CHK("pin_oe", m_dir, pin_oe)
      `CHK("pin_out", m_dat & m_dir, pin_out)
      sweep();
      close_out();
   end
endmodule : profile_and_sync_register_bank_tb_top
